// [cod_pkg.sv]
// Purpose: Shared constants for the clock output divider block.
// Assumes: Registers sit in the low byte of 32-bit classic Wishbone words.
// Notes: Peripheral and subsystem clocks arrive as levels sampled by clk_i.
package cod_pkg;
  localparam int ADR_W = 16;
  localparam logic [ADR_W-1:0] CKS_OFF = 16'hff40;
  localparam logic [ADR_W-1:0] DIR_OFF = 16'hff44;
  localparam logic [ADR_W-1:0] LATCH_OFF = 16'hff48;
  localparam logic [ADR_W-1:0] STAT_OFF = 16'hff4c;
  localparam logic [4:0] CKS_RST = 5'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam int EN_BIT = 4;
  localparam int SEL_MSB = 3;
  localparam int PIN_BIT = 0;
  localparam logic [3:0] SUB_SEL = 4'h8;
  localparam int CNT_W = 7;
endpackage

// [cod_divider.sv]
// Purpose: Power-of-two divider and source selector for the clock output.
// Assumes: prs_lvl_i and sub_lvl_i are levels synchronous to clk_i.
// Notes: The counter is held at zero while run_i is low.
`timescale 1ns/1ns
module cod_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [cod_pkg::SEL_MSB:0] sel_i,
  input wire logic prs_lvl_i,
  input wire logic sub_lvl_i,
  output logic src_o
);
  import cod_pkg::*;

  typedef struct packed {
    logic prs_d;
    logic [CNT_W-1:0] cnt;
    logic src;
  } cod_div_st_t;

  cod_div_st_t st_reg;
  cod_div_st_t st_next;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.prs_d = prs_lvl_i;
    if (!run_i) begin
      st_next.cnt = '0;
    end else if (prs_lvl_i && !st_reg.prs_d) begin
      st_next.cnt = st_reg.cnt + 7'h01;
    end
    // Bit n-1 of the edge counter has a period of 2^n peripheral cycles.
    if (sel_i == 4'h0) begin
      st_next.src = prs_lvl_i;
    end else if (sel_i <= 4'h7) begin
      st_next.src = st_reg.cnt[sel_i[2:0] - 3'h1];
    end else if (sel_i == SUB_SEL) begin
      st_next.src = sub_lvl_i;
    end else begin
      st_next.src = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign src_o = st_reg.src;

  //////////////////////////////////////////////////////////////////////////////
  a_halt_count: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_i |=> st_reg.cnt == '0)
    else $error("divider counter not held while stopped");

  a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_i && prs_lvl_i && !st_reg.prs_d) |=> st_reg.cnt == $past(st_reg.cnt) + 7'h01)
    else $error("divider counter missed a peripheral edge");

  a_sub_route: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_i == SUB_SEL |=> src_o == $past(sub_lvl_i))
    else $error("subsystem clock not routed");

  a_refused_low: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_i > SUB_SEL |=> !src_o)
    else $error("prohibited code produced a clock");
endmodule

// [cod_top.sv]
// Purpose: Clock output unit with its select, direction and latch registers.
// Assumes: Classic Wishbone slave, one clock, synchronous active-high reset.
// Notes: The pin ORs the port latch with the gated clock, so the latch must be 0.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
module cod_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cod_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic prs_clk_i,
  input wire logic sub_clk_i,
  input wire logic clock_out_pin_i,
  output logic clock_out_pin_o,
  output logic clock_out_pin_oe_o
);
  import cod_pkg::*;

  typedef struct packed {
    logic [4:0] clock_output_select;
    logic [7:0] dir;
    logic [7:0] latch;
    logic on;
    logic out;
    logic ack;
    logic [31:0] rdat;
  } cod_main_st_t;

  cod_main_st_t st_reg;
  cod_main_st_t st_next;
  logic src;
  logic run;
  logic req;
  logic wr_lo;
  logic clk_out_enable;
  logic [SEL_MSB:0] div_sel;

  //////////////////////////////////////////////////////////////////////////////
  assign clk_out_enable = st_reg.clock_output_select[EN_BIT];
  assign div_sel = st_reg.clock_output_select[SEL_MSB:0];
  // The divider keeps running until the gate has closed on a low phase.
  assign run = clk_out_enable | st_reg.on;
  assign req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign wr_lo = req & wb_we_i & wb_sel_i[0];

  cod_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .sel_i(div_sel),
    .prs_lvl_i(prs_clk_i),
    .sub_lvl_i(sub_clk_i),
    .src_o(src)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    // The gate may only change while the selected clock is low.
    if (!src) begin
      st_next.on = clk_out_enable;
    end
    st_next.out = st_reg.on & src;
    st_next.ack = req;
    st_next.rdat = '0;
    if (wr_lo) begin
      case (wb_adr_i)
        CKS_OFF: begin
          st_next.clock_output_select = wb_dat_i[4:0];
        end
        DIR_OFF: begin
          st_next.dir = wb_dat_i[7:0];
        end
        LATCH_OFF: begin
          st_next.latch = wb_dat_i[7:0];
        end
        default: begin
        end
      endcase
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        CKS_OFF: begin
          st_next.rdat = {27'h0, st_reg.clock_output_select};
        end
        DIR_OFF: begin
          st_next.rdat = {24'h0, st_reg.dir};
        end
        LATCH_OFF: begin
          st_next.rdat = {24'h0, st_reg.latch};
        end
        STAT_OFF: begin
          st_next.rdat = {28'h0, clock_out_pin_i, st_reg.out, src, st_reg.on};
        end
        default: begin
          st_next.rdat = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg.clock_output_select <= CKS_RST;
      st_reg.dir <= DIR_RST;
      st_reg.latch <= LATCH_RST;
      st_reg.on <= 1'b0;
      st_reg.out <= 1'b0;
      st_reg.ack <= 1'b0;
      st_reg.rdat <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign wb_dat_o = st_reg.rdat;
  assign wb_ack_o = st_reg.ack;
  assign clock_out_pin_o = st_reg.latch[PIN_BIT] | st_reg.out;
  assign clock_out_pin_oe_o = ~st_reg.dir[PIN_BIT];

  //////////////////////////////////////////////////////////////////////////////
  a_reset_select: assert property (@(posedge clk_i)
    rst_i |=> (st_reg.clock_output_select == CKS_RST) && !st_reg.on)
    else $error("select register not cleared by reset");

  a_reset_dir: assert property (@(posedge clk_i)
    rst_i |=> st_reg.dir == DIR_RST && clock_out_pin_oe_o == 1'b0)
    else $error("direction register not all ones after reset");

  a_stop_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (!clk_out_enable && !st_reg.on) ##1 !st_reg.on |-> !st_reg.out)
    else $error("clock output not low while disabled");

  a_run_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.on && src) |=> st_reg.out)
    else $error("selected clock not driven while enabled");

  a_start_low: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_reg.on) |-> !$past(src) && !st_reg.out)
    else $error("output gate opened during a high phase");

  a_stop_after_high: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(st_reg.on) |-> !$past(src) && !$past(clk_out_enable))
    else $error("output gate closed during a high phase");

  a_byte_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lo && wb_adr_i == CKS_OFF) |=> st_reg.clock_output_select == $past(wb_dat_i[4:0]) && wb_ack_o)
    else $error("select register write lost");

  a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && wb_adr_i == CKS_OFF) |=> wb_dat_o[31:5] == '0
      && wb_dat_o[4:0] == $past(st_reg.clock_output_select))
    else $error("select register upper bits not zero");

  a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for more than one cycle");

  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("bus request not acknowledged in one cycle");

  a_data_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside acknowledge");

  a_lane_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && !wb_sel_i[0]) |=> $stable(st_reg.clock_output_select))
    else $error("write without low byte lane changed the select register");

  a_pin_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (!clk_out_enable && !st_reg.on && !st_reg.latch[PIN_BIT] && !wr_lo)
      |=> !clock_out_pin_o)
    else $error("clock output pin not low while stopped");

  a_gate_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    src |=> st_reg.on == $past(st_reg.on))
    else $error("output gate changed during a high phase");
endmodule

// [cod_load_model.sv]
// Purpose: Load on the clock output pin, measuring its high phases.
// Assumes: The pin is sampled on clk_i; a released pin is pulled low.
// Notes: min_len_o holds the shortest completed high phase since clr_i.
`timescale 1ns/1ns
module cod_load_model (
  input wire logic clk_i,
  input wire logic pin_i,
  input wire logic clr_i,
  output logic [15:0] min_len_o
);
  logic [15:0] run;
  logic prev;
  always_ff @(posedge clk_i) begin
    prev <= pin_i;
    if (pin_i) run <= prev ? run + 16'h1 : 16'h1;
    if (clr_i) min_len_o <= 16'hffff;
    else if (prev && !pin_i && run < min_len_o) min_len_o <= run;
  end
endmodule

// [test_clock_output_divider.sv]
// Purpose: Self-checking bench of the clock output unit.
// Assumes: Peripheral clock period 4 cycles, subsystem clock period 10 cycles.
// Notes: Each row sets a code, runs the output and checks the pulse width.
`timescale 1ns/1ns
module test_clock_output_divider;
  import cod_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, clr;
  logic prs_clk_i = 1'b0;
  logic sub_clk_i = 1'b0;
  logic [3:0] pc = 4'h0;
  logic [3:0] sc = 4'h0;
  int cycles = 0;
  logic [7:0] row_code [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h09};
  logic [15:0] row_width [10] = '{16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
    16'h0040, 16'h0080, 16'h0100, 16'h0005, 16'hffff};
  logic [15:0] wb_adr_i, min_len;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic [7:0] q;
  logic wb_ack_o, clock_out_pin_o, clock_out_pin_oe_o, pin_w;
  int mismatches, tests_run;
  assign pin_w = clock_out_pin_oe_o ? clock_out_pin_o : 1'b0;
  cod_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .prs_clk_i, .sub_clk_i, .clock_out_pin_i(pin_w),
    .clock_out_pin_o, .clock_out_pin_oe_o);
  cod_load_model load_u (.clk_i, .pin_i(pin_w), .clr_i(clr), .min_len_o(min_len));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    pc <= pc + 4'h1;
    sc <= (sc == 4'h9) ? 4'h0 : sc + 4'h1;
    prs_clk_i <= pc[1];
    sub_clk_i <= (sc > 4'h4);
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d,
      input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i} = '0;
    {wb_adr_i, wb_dat_i, wb_sel_i, mismatches, tests_run} = '0;
    rst_i = 1'b1;
    clr = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int r = 0; r < 10; r++) begin
      wb(1'b0, CKS_OFF, 8'h00, 4'h1);
      chk("cks_reset", {8'h0, q}, 16'h0);
      wb(1'b0, DIR_OFF, 8'h00, 4'h1);
      chk("dir_reset", {8'h0, q}, 16'hff);
      chk("pin_reset", {14'h0, clock_out_pin_o, clock_out_pin_oe_o}, 16'h0);
      wb(1'b1, DIR_OFF, 8'h00, 4'h1);
      wb(1'b1, LATCH_OFF, 8'h00, 4'h1);
      wb(1'b1, CKS_OFF, 8'he0 | row_code[r], 4'h1);
      wb(1'b1, CKS_OFF, 8'h1f, 4'h2);
      wb(1'b0, CKS_OFF, 8'h00, 4'h1);
      chk("cks_code", {8'h0, q}, {8'h0, row_code[r]});
      wb(1'b0, 16'hff50, 8'h00, 4'h1);
      chk("unmapped", {8'h0, q}, 16'h0);
      clr <= 1'b0;
      wb(1'b1, CKS_OFF, 8'h10 | row_code[r], 4'h1);
      repeat (1100) @(posedge clk_i);
      wb(1'b1, CKS_OFF, row_code[r], 4'h1);
      repeat (600) @(posedge clk_i);
      chk("pulse_width", min_len, row_width[r]);
      chk("pin_stopped", {15'h0, clock_out_pin_o}, 16'h0);
      wb(1'b0, STAT_OFF, 8'h00, 4'h1);
      chk("status_stopped", {8'h0, q & 8'h0d}, 16'h0);
      clr <= 1'b1;
      $display("test row %0d done", r);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
    end
    wb(1'b1, DIR_OFF, 8'h00, 4'h1);
    wb(1'b1, CKS_OFF, 8'h03, 4'h1);
    wb(1'b1, CKS_OFF, 8'h13, 4'h1);
    repeat (50) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("pin_after_reset", {14'h0, clock_out_pin_o, clock_out_pin_oe_o}, 16'h0);
    wb(1'b0, CKS_OFF, 8'h00, 4'h1);
    chk("cks_after_reset", {8'h0, q}, 16'h0);
    wb(1'b0, DIR_OFF, 8'h00, 4'h1);
    chk("dir_after_reset", {8'h0, q}, 16'hff);
    $display("test mid_reset done");
    conclude();
  end
endmodule
